// ==== common/bfs_pkg.sv ====
// shared constants for the backlight fault supervisor
package bfs_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] OFF_FAULT_A    = 8'h00;
  localparam logic [7:0] OFF_FAULT_B    = 8'h04;
  localparam logic [7:0] OFF_CFG_FOUR   = 8'h08;
  localparam logic [7:0] OFF_STR_MASK   = 8'h0C;
  localparam logic [7:0] OFF_CFG_THREE  = 8'h10;
  localparam logic [7:0] OFF_OV_LEVEL   = 8'h14;
  localparam logic [7:0] OFF_STATE      = 8'h18;

  // fault_status_a bit positions
  localparam int FA_OUT_OV   = 0;
  localparam int FA_BN_OV    = 1;
  localparam int FA_BN_UV    = 2;
  localparam int FA_SS_TMO   = 3;
  localparam int FA_LED_SHRT = 4;
  localparam int FA_W        = 5;

  // config_reg_four bit positions
  localparam int C4_RESET   = 0;
  localparam int C4_STANDBY = 1;

  // state register field positions
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_SHORT_LO = 8;

  localparam int NSTR = 8;

  // reset values and the lowest accepted overvoltage level code
  localparam logic [3:0] OV_LEVEL_RST  = 4'h2;
  localparam logic [1:0] SHORT_THR_RST = 2'h0;
  localparam logic [7:0] MASK_RST      = 8'h00;
  localparam logic [3:0] OV_LEVEL_MIN  = 4'h2;

  // soft-start window
  localparam int CLK_MHZ      = 40;
  localparam int SS_TIME_US   = 10000;
  localparam int SS_CYCLES    = SS_TIME_US * CLK_MHZ;
  localparam int SS_CNT_W     = 20;

  typedef enum logic [2:0] {
    BFS_OFF, BFS_READY, BFS_CHECK, BFS_SOFT, BFS_RUN, BFS_STANDBY
  } bfs_state_e;
endpackage

// ==== hdl/bfs_supervisor.sv ====
// fault supervision and operating-state control with apb registers
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module bfs_supervisor #(
  parameter int SS_LIMIT = bfs_pkg::SS_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        en_pin_in,
  input  wire logic        vcc_uv_in,
  input  wire logic        vbat_uv_in,
  input  wire logic        out_ov_cmp_in,
  input  wire logic        boost_node_ov_cmp_in,
  input  wire logic        boost_node_uv_cmp_in,
  input  wire logic        inductor_open_in,
  input  wire logic        out_above_2x_in,
  input  wire logic [7:0]  led_in_reg_in,
  input  wire logic [7:0]  led_over_short_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             ref_en_out,
  output logic             boost_en_out,
  output logic             chargepump_en_out,
  output logic             driver_standby_out,
  output logic             short_cmp_en_out,
  output logic      [7:0]  sink_en_out,
  output logic      [3:0]  out_ov_threshold_sel_out,
  output logic      [1:0]  shorted_string_threshold_out,
  output logic      [2:0]  state_out
);

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_n;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  bfs_pkg::bfs_state_e state_ff;
  bfs_pkg::bfs_state_e nxt_state;
  logic [bfs_pkg::FA_W-1:0]     fault_a_ff;
  logic [bfs_pkg::FA_W-1:0]     nxt_fault_a;
  logic [bfs_pkg::NSTR-1:0]     fault_b_ff;
  logic [bfs_pkg::NSTR-1:0]     nxt_fault_b;
  logic [bfs_pkg::NSTR-1:0]     mask_ff;
  logic [bfs_pkg::NSTR-1:0]     short_off_ff;
  logic [bfs_pkg::NSTR-1:0]     nxt_short_off;
  logic [3:0]                   ov_level_ff;
  logic [1:0]                   short_thr_ff;
  logic                         standby_ff;
  logic                         reset_ff;
  logic                         lockout_ff;
  logic                         nxt_lockout;
  logic [bfs_pkg::SS_CNT_W-1:0] ss_cnt_ff;
  logic [31:0]                  prdata_ff;

  // supply and enable qualification
  wire uvlo      = vcc_uv_in | vbat_uv_in;
  wire active    = en_pin_in & ~uvlo;
  wire clr_all   = ~active | reset_ff;
  wire go        = active & ~reset_ff & ~standby_ff;
  wire mask_zero = (mask_ff == '0);

  wire in_check = (state_ff == bfs_pkg::BFS_CHECK);
  wire in_soft  = (state_ff == bfs_pkg::BFS_SOFT);
  wire in_run   = (state_ff == bfs_pkg::BFS_RUN);

  // fault trips that latch the converter off
  wire open_trip = go & in_check & inductor_open_in;
  wire uv_trip   = go & in_run & boost_node_uv_cmp_in;
  wire ss_expire = (ss_cnt_ff == bfs_pkg::SS_CNT_W'(SS_LIMIT - 1));
  wire ss_trip   = go & in_soft & ~mask_zero & ~out_above_2x_in
                   & ss_expire;

  // apb decode
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == bfs_pkg::OFF_FAULT_A)   |
                  (a == bfs_pkg::OFF_FAULT_B)   |
                  (a == bfs_pkg::OFF_CFG_FOUR)  |
                  (a == bfs_pkg::OFF_STR_MASK)  |
                  (a == bfs_pkg::OFF_CFG_THREE) |
                  (a == bfs_pkg::OFF_OV_LEVEL)  |
                  (a == bfs_pkg::OFF_STATE);
  endfunction

  wire setup  = psel_in & ~penable_in;
  wire access = psel_in & penable_in;
  wire wr_ok  = access & pwrite_in & addr_mapped(paddr_in) & ~clr_all;
  wire rd_acc = access & ~pwrite_in;
  wire wr_c4  = wr_ok & (paddr_in == bfs_pkg::OFF_CFG_FOUR);
  wire wr_msk = wr_ok & (paddr_in == bfs_pkg::OFF_STR_MASK);
  wire wr_c3  = wr_ok & (paddr_in == bfs_pkg::OFF_CFG_THREE);
  // reserved low threshold codes are refused, level is kept
  wire wr_ovl = wr_ok & (paddr_in == bfs_pkg::OFF_OV_LEVEL)
                & (pwdata_in[3:0] >= bfs_pkg::OV_LEVEL_MIN);
  // the clear uses the word latched in setup, so a flag raised
  // between setup and access is never wiped unseen
  wire clr_a  = rd_acc & (paddr_in == bfs_pkg::OFF_FAULT_A);
  wire clr_b  = rd_acc & (paddr_in == bfs_pkg::OFF_FAULT_B);

  wire [31:0] rd_word =
    (paddr_in == bfs_pkg::OFF_FAULT_A)   ? 32'(fault_a_ff)  :
    (paddr_in == bfs_pkg::OFF_FAULT_B)   ? 32'(fault_b_ff)  :
    (paddr_in == bfs_pkg::OFF_CFG_FOUR)  ?
      32'({standby_ff, reset_ff})                            :
    (paddr_in == bfs_pkg::OFF_STR_MASK)  ? 32'(mask_ff)     :
    (paddr_in == bfs_pkg::OFF_CFG_THREE) ? 32'(short_thr_ff) :
    (paddr_in == bfs_pkg::OFF_OV_LEVEL)  ? 32'(ov_level_ff) :
    (paddr_in == bfs_pkg::OFF_STATE)     ?
      32'({short_off_ff, 4'h0, lockout_ff, state_ff})        :
    32'h0000_0000;

  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~addr_mapped(paddr_in);
  assign prdata_out  = prdata_ff;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      prdata_ff <= 32'h0000_0000;
    else if (setup && !pwrite_in)
      prdata_ff <= rd_word;
  end

  // string short handling
  logic [bfs_pkg::NSTR-1:0] sink_w;
  logic [bfs_pkg::NSTR-1:0] short_hit;
  wire sink_gate = active & in_run & ~lockout_ff & ~standby_ff
                   & ~boost_node_uv_cmp_in;
  wire short_arm = active & in_run & ~lockout_ff
                   & (|led_in_reg_in);

  genvar gi;
  generate
    for (gi = 0; gi < bfs_pkg::NSTR; gi++)
    begin : g_str
      assign sink_w[gi]    = sink_gate & mask_ff[gi]
                             & ~short_off_ff[gi];
      assign short_hit[gi] = short_arm & sink_w[gi]
                             & led_over_short_in[gi];
    end
  endgenerate

  // host turning every sink off is the only clear besides reset
  always_comb
  begin
    if (clr_all || mask_zero)
      nxt_short_off = '0;
    else
      nxt_short_off = short_off_ff | short_hit;
  end

  // fault flags: set beats clear-on-read
  logic [bfs_pkg::FA_W-1:0] set_a;
  always_comb
  begin
    set_a = '0;
    set_a[bfs_pkg::FA_OUT_OV]   = active & out_ov_cmp_in;
    set_a[bfs_pkg::FA_BN_OV]    = active & boost_node_ov_cmp_in;
    set_a[bfs_pkg::FA_BN_UV]    = uv_trip | open_trip;
    set_a[bfs_pkg::FA_SS_TMO]   = ss_trip | open_trip;
    set_a[bfs_pkg::FA_LED_SHRT] = |short_hit;
    if (clr_all)
    begin
      nxt_fault_a = '0;
      nxt_fault_b = '0;
    end
    else
    begin
      nxt_fault_a = (fault_a_ff
                     & ~(clr_a ? prdata_ff[bfs_pkg::FA_W-1:0] : '0))
                    | set_a;
      nxt_fault_b = (fault_b_ff
                     & ~(clr_b ? prdata_ff[bfs_pkg::NSTR-1:0] : '0))
                    | short_hit;
    end
  end

  // latched lockout from open inductor, boost-node uv, timeout
  assign nxt_lockout = clr_all ? 1'b0 :
                       (lockout_ff | open_trip | uv_trip
                        | ss_trip);

  // operating state decode
  always_comb
  begin
    nxt_state = state_ff;
    if (!active)
      nxt_state = bfs_pkg::BFS_OFF;
    else if (reset_ff)
      nxt_state = bfs_pkg::BFS_READY;
    else if (standby_ff)
      nxt_state = bfs_pkg::BFS_STANDBY;
    else
    begin
      unique case (state_ff)
        bfs_pkg::BFS_OFF:     nxt_state = bfs_pkg::BFS_READY;
        bfs_pkg::BFS_READY:
          if (!mask_zero && !lockout_ff)
            nxt_state = bfs_pkg::BFS_CHECK;
        bfs_pkg::BFS_CHECK:
          nxt_state = inductor_open_in ? bfs_pkg::BFS_READY
                                       : bfs_pkg::BFS_SOFT;
        bfs_pkg::BFS_SOFT:
          if (mask_zero || ss_trip)
            nxt_state = bfs_pkg::BFS_READY;
          else if (out_above_2x_in)
            nxt_state = bfs_pkg::BFS_RUN;
        bfs_pkg::BFS_RUN:
          if (mask_zero || uv_trip)
            nxt_state = bfs_pkg::BFS_READY;
        bfs_pkg::BFS_STANDBY: nxt_state = bfs_pkg::BFS_READY;
        default:              nxt_state = bfs_pkg::BFS_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff     <= bfs_pkg::BFS_OFF;
      fault_a_ff   <= '0;
      fault_b_ff   <= '0;
      short_off_ff <= '0;
      lockout_ff   <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      fault_a_ff   <= nxt_fault_a;
      fault_b_ff   <= nxt_fault_b;
      short_off_ff <= nxt_short_off;
      lockout_ff   <= nxt_lockout;
    end
  end

  // soft-start timer only runs in the soft state
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ss_cnt_ff <= '0;
    else if (clr_all || !in_soft)
      ss_cnt_ff <= '0;
    else if (!ss_expire)
      ss_cnt_ff <= ss_cnt_ff + 1'b1;
  end

  // software registers, wiped by any reset event
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_ff      <= bfs_pkg::MASK_RST;
      ov_level_ff  <= bfs_pkg::OV_LEVEL_RST;
      short_thr_ff <= bfs_pkg::SHORT_THR_RST;
      standby_ff   <= 1'b0;
      reset_ff     <= 1'b0;
    end
    else if (clr_all)
    begin
      mask_ff      <= bfs_pkg::MASK_RST;
      ov_level_ff  <= bfs_pkg::OV_LEVEL_RST;
      short_thr_ff <= bfs_pkg::SHORT_THR_RST;
      standby_ff   <= 1'b0;
      reset_ff     <= 1'b0;
    end
    else
    begin
      if (wr_msk)
        mask_ff <= pwdata_in[bfs_pkg::NSTR-1:0];
      if (wr_ovl)
        ov_level_ff <= pwdata_in[3:0];
      if (wr_c3)
        short_thr_ff <= pwdata_in[1:0];
      if (wr_c4)
      begin
        standby_ff <= pwdata_in[bfs_pkg::C4_STANDBY];
        // reset is honoured only out of standby
        reset_ff   <= pwdata_in[bfs_pkg::C4_RESET]
                      & ~standby_ff;
      end
    end
  end

  // analog control outputs
  wire conv_on = active & (in_soft | in_run) & ~lockout_ff
                 & ~standby_ff & ~reset_ff;
  assign chargepump_en_out  = conv_on;
  assign boost_en_out       = conv_on & ~out_ov_cmp_in
                              & ~boost_node_ov_cmp_in
                              & ~(in_run & boost_node_uv_cmp_in);
  assign ref_en_out         = active
                              & (state_ff != bfs_pkg::BFS_STANDBY)
                              & (state_ff != bfs_pkg::BFS_OFF);
  assign driver_standby_out = active
                              & (state_ff == bfs_pkg::BFS_READY);
  assign sink_en_out        = sink_w;
  assign short_cmp_en_out   = short_arm;
  assign out_ov_threshold_sel_out     = ov_level_ff;
  assign shorted_string_threshold_out = short_thr_ff;
  assign state_out                    = state_ff;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_uv_in_run;
    go && in_run && boost_node_uv_cmp_in;
  endsequence
  sequence s_no_reset_2;
    active && !reset_ff [*2];
  endsequence

  a_uvlo_all_off: assert property (
    uvlo |-> !boost_en_out && sink_en_out == '0 && !ref_en_out
    ##1 state_ff == bfs_pkg::BFS_OFF)
    else $error("supplies low but outputs still on");
  a_por_clears: assert property (
    !active |=> fault_a_ff == '0 && mask_ff == '0 && !lockout_ff)
    else $error("power-on reset left state behind");
  a_out_ov_stop: assert property (
    out_ov_cmp_in |-> !boost_en_out
    ##1 (fault_a_ff[bfs_pkg::FA_OUT_OV] || $past(clr_all)))
    else $error("output overvoltage not handled");
  a_bn_ov_stop: assert property (
    active && boost_node_ov_cmp_in |-> !boost_en_out
    ##1 (fault_a_ff[bfs_pkg::FA_BN_OV] || $past(reset_ff)))
    else $error("boost-node overvoltage not handled");
  a_bn_uv_latch: assert property (
    s_uv_in_run ##1 s_no_reset_2 |->
    lockout_ff && sink_en_out == '0 && !boost_en_out)
    else $error("boost-node undervoltage not latched");
  a_open_ind_flags: assert property (
    open_trip |=> fault_a_ff[bfs_pkg::FA_SS_TMO]
    && fault_a_ff[bfs_pkg::FA_BN_UV] && lockout_ff
    && state_ff == bfs_pkg::BFS_READY)
    else $error("open inductor not flagged");
  a_ss_timeout: assert property (
    in_soft && ss_cnt_ff == bfs_pkg::SS_CNT_W'(SS_LIMIT - 1)
    && go && !mask_zero && !out_above_2x_in
    |=> lockout_ff && fault_a_ff[bfs_pkg::FA_SS_TMO] && !boost_en_out)
    else $error("soft-start timeout missed");
  a_standby_off: assert property (
    state_ff == bfs_pkg::BFS_STANDBY |->
    !boost_en_out && !ref_en_out && sink_en_out == '0)
    else $error("standby left blocks on");
  a_reset_selfclr: assert property (
    reset_ff |=> !reset_ff && mask_ff == '0
    && (state_ff == bfs_pkg::BFS_READY || !$past(active)))
    else $error("reset bit did not self-clear");
  a_set_beats_clr: assert property (
    clr_a && set_a[bfs_pkg::FA_OUT_OV] && !clr_all
    |=> fault_a_ff[bfs_pkg::FA_OUT_OV])
    else $error("fault lost on read clear");
  a_short_only: assert property (
    (|short_hit) && !clr_all && !mask_zero |=>
    ($past(short_hit) & (sink_en_out | ~fault_b_ff)) == '0)
    else $error("shorted string still driven");
endmodule

// ==== dv/bfs_plant_model.sv ====
// analog plant stand-in: boost output, inductor and led string sense
`timescale 1ns/1ps
module bfs_plant_model #(
  parameter int RISE = 5
) (
  input  wire logic       clk_in,
  input  wire logic       boost_en_in,
  input  wire logic [7:0] sink_en_in,
  input  wire logic       slow_in,
  input  wire logic       open_in,
  input  wire logic [7:0] short_in,
  output logic            out_above_2x_out,
  output logic            inductor_open_out,
  output logic      [7:0] led_in_reg_out,
  output logic      [7:0] led_over_short_out
);
  int cnt_ff;

  // output collapses as soon as switching stops, so a restart ramps again
  always_ff @(posedge clk_in)
    cnt_ff <= boost_en_in ? ((cnt_ff < RISE) ? cnt_ff + 1 : cnt_ff) : 0;

  // slow_in models a load that never lets the output reach twice battery
  assign out_above_2x_out   = !slow_in && cnt_ff >= RISE;
  assign inductor_open_out  = open_in;
  // a shorted string sits above threshold instead of in regulation
  assign led_in_reg_out     = sink_en_in & ~short_in;
  assign led_over_short_out = sink_en_in & short_in;
endmodule

// ==== dv/bfs_supervisor_test.sv ====
// self-checking bench for the backlight fault supervisor
`timescale 1ns/1ps
module bfs_supervisor_test;
  localparam int SSL = 20;
  logic        clk_in    = 1'b0;
  logic        resetn_in = 1'b0;
  logic        en        = 1'b0;
  logic [1:0]  uv        = 2'h0;
  logic [1:0]  ovs       = 2'h0;
  logic        bn_uv     = 1'b0;
  logic        slow      = 1'b0;
  logic        open      = 1'b0;
  logic [7:0]  shorts    = 8'h00;
  logic        psel      = 1'b0;
  logic        pen       = 1'b0;
  logic        pwr       = 1'b0;
  logic [7:0]  padr      = 8'h00;
  logic [31:0] pwd       = 32'h0;
  logic [31:0] prd;
  logic [31:0] q;
  logic        prdy, perr, err, ref_en, bst, cp, stby, scmp, above, ind;
  logic [7:0]  sink, inreg, over;
  logic [3:0]  ovsel;
  logic [1:0]  sthr;
  logic [2:0]  st;
  int          bad_count = 0;
  int          tests_run = 0;
  int          i;

  bfs_supervisor #(.SS_LIMIT(SSL)) dut (.clk_in(clk_in),
    .resetn_in(resetn_in), .en_pin_in(en), .vcc_uv_in(uv[0]),
    .vbat_uv_in(uv[1]), .out_ov_cmp_in(ovs[0]),
    .boost_node_ov_cmp_in(ovs[1]), .boost_node_uv_cmp_in(bn_uv),
    .inductor_open_in(ind), .out_above_2x_in(above),
    .led_in_reg_in(inreg), .led_over_short_in(over), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .ref_en_out(ref_en), .boost_en_out(bst), .chargepump_en_out(cp),
    .driver_standby_out(stby), .short_cmp_en_out(scmp),
    .sink_en_out(sink), .out_ov_threshold_sel_out(ovsel),
    .shorted_string_threshold_out(sthr), .state_out(st));

  bfs_plant_model #(.RISE(5)) plant (.clk_in(clk_in), .boost_en_in(bst),
    .sink_en_in(sink), .slow_in(slow), .open_in(open), .short_in(shorts),
    .out_above_2x_out(above), .inductor_open_out(ind),
    .led_in_reg_out(inreg), .led_over_short_out(over));

  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // lands just after an edge so combinational outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (prdy !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      stop_test();
    end
    q = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic wait_st(input logic [2:0] e);
    int n;
    n = 0;
    do
    begin
      settle(1);
      n++;
    end
    while (st !== e && n < 60);
    chk(32'(st), 32'(e));
  endtask

  initial
  begin
    step(3);
    resetn_in <= 1'b1;
    wait_st(3'h0);
    step(1);
    en <= 1'b1;
    wait_st(3'h1);
    chk(32'({ref_en, bst, cp, stby}), 32'h9);
    for (i = 0; i < 16; i++)
    begin
      apb(1'b1, bfs_pkg::OFF_OV_LEVEL, 32'(i));
      rd(bfs_pkg::OFF_OV_LEVEL, (i < 2) ? 32'h2 : 32'(i));
      chk(32'(ovsel), (i < 2) ? 32'h2 : 32'(i));
    end
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, bfs_pkg::OFF_CFG_THREE, 32'(i));
      settle(1);
      chk(32'(sthr), 32'(i));
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({q[30:0], err}, 32'h1);
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'hFF);
    wait_st(3'h4);
    chk(32'({bst, sink}), 32'h1FF);
    chk(32'({ref_en, cp, stby, scmp}), 32'hD);
    for (i = 0; i < 2; i++)
    begin
      rd(bfs_pkg::OFF_FAULT_A, 32'h0);
      step(1);
      ovs[i] <= 1'b1;
      settle(1);
      chk(32'(bst), 32'h0);
      rd(bfs_pkg::OFF_FAULT_A, 32'h1 << i);
      rd(bfs_pkg::OFF_FAULT_A, 32'h1 << i);
      step(1);
      ovs[i] <= 1'b0;
      settle(2);
      chk(32'(bst), 32'h1);
      rd(bfs_pkg::OFF_FAULT_A, 32'h1 << i);
      rd(bfs_pkg::OFF_FAULT_A, 32'h0);
    end
    step(1);
    shorts <= 8'h08;
    settle(4);
    chk(32'({scmp, sink}), 32'h1F7);
    rd(bfs_pkg::OFF_FAULT_A, 32'h10);
    rd(bfs_pkg::OFF_FAULT_B, 32'h08);
    step(1);
    shorts <= 8'h00;
    settle(4);
    chk(32'(sink), 32'hF7);
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'h0);
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'hFF);
    wait_st(3'h4);
    chk(32'(sink), 32'hFF);
    step(1);
    bn_uv <= 1'b1;
    settle(2);
    chk(32'({bst, sink}), 32'h0);
    step(1);
    bn_uv <= 1'b0;
    settle(6);
    chk(32'({bst, sink}), 32'h0);
    rd(bfs_pkg::OFF_FAULT_A, 32'h4);
    apb(1'b1, bfs_pkg::OFF_CFG_FOUR, 32'h1);
    wait_st(3'h1);
    rd(bfs_pkg::OFF_STR_MASK, 32'h0);
    rd(bfs_pkg::OFF_CFG_FOUR, 32'h0);
    rd(bfs_pkg::OFF_OV_LEVEL, 32'h2);
    rd(bfs_pkg::OFF_STATE, 32'h1);
    step(1);
    slow <= 1'b1;
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'hFF);
    settle(SSL + 10);
    chk(32'({bst, sink}), 32'h0);
    rd(bfs_pkg::OFF_FAULT_A, 32'h8);
    apb(1'b0, bfs_pkg::OFF_STATE, 32'h0);
    chk(32'(q[3]), 32'h1);
    step(1);
    slow <= 1'b0;
    settle(20);
    chk(32'(st == 3'h4), 32'h0);
    apb(1'b1, bfs_pkg::OFF_CFG_FOUR, 32'h1);
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'hFF);
    wait_st(3'h4);
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'h0);
    wait_st(3'h1);
    step(1);
    open <= 1'b1;
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'hFF);
    settle(4);
    chk(32'({bst, sink}), 32'h0);
    rd(bfs_pkg::OFF_FAULT_A, 32'hC);
    step(1);
    open <= 1'b0;
    en <= 1'b0;
    wait_st(3'h0);
    step(1);
    en <= 1'b1;
    wait_st(3'h1);
    rd(bfs_pkg::OFF_STATE, 32'h1);
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'hFF);
    wait_st(3'h4);
    apb(1'b1, bfs_pkg::OFF_CFG_FOUR, 32'h2);
    wait_st(3'h5);
    chk(32'({bst, cp, sink}), 32'h0);
    chk(32'({ref_en, stby, scmp}), 32'h0);
    apb(1'b1, bfs_pkg::OFF_CFG_FOUR, 32'h3);
    rd(bfs_pkg::OFF_CFG_FOUR, 32'h2);
    apb(1'b1, bfs_pkg::OFF_CFG_FOUR, 32'h0);
    apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, bfs_pkg::OFF_STR_MASK, 32'hFF);
      wait_st(3'h4);
      step(1);
      uv[i] <= 1'b1;
      settle(3);
      chk(32'({ref_en, bst, cp, sink}), 32'h0);
      chk(32'(st), 32'h0);
      step(1);
      uv[i] <= 1'b0;
      wait_st(3'h1);
      rd(bfs_pkg::OFF_STR_MASK, 32'h0);
    end
    stop_test();
  end

  // a hang anywhere ends the run through the same report
  initial
  begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    stop_test();
  end
endmodule
